// ===== src/set_features_command_handler.sv
// Set-features command interpreter with task-file register port and feature state
`include "set_features_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module set_features_command_handler (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // Task-file register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Soft reset request and cache flush handshake
   input wire logic soft_reset_in,
   input wire logic flush_done_in,
   output logic flush_req_out,
   // Command status
   output logic busy_out,
   output logic cmd_done_out,
   output logic cmd_abort_out,
   // Feature state
   output logic wide_transfer_indicator_n_out,
   output logic write_cache_en_out,
   output logic [2:0] pio_mode_out,
   output logic iordy_en_out,
   output logic dma_is_udma_out,
   output logic [2:0] dma_mode_out,
   output logic apm_en_out,
   output logic [7:0] apm_level_out,
   output logic ext_power_en_out,
   output logic pl1_en_out,
   output logic look_ahead_en_out,
   output logic long_4byte_out,
   output logic [7:0] current_limit_out,
   output logic por_restore_out
);

   set_features_pkg::ctl_type s_q;
   set_features_pkg::ctl_type s_d;
   logic exec_ok;

   // Power-on feature defaults, applied by soft reset; hardware reset loads the same values
   function automatic set_features_pkg::ctl_type with_defaults(
      input set_features_pkg::ctl_type s);
      set_features_pkg::ctl_type r;
      r = s;
      r.eight_bit = 1'b0;
      r.wcache = 1'b0;
      r.pio = 3'h0;
      r.iordy_en = 1'b1;
      r.dma_udma = 1'b0;
      r.dma_mode = 3'h0;
      r.apm_en = 1'b0;
      r.apm_lvl = `APM_RESERVED_HI;
      r.ext_pwr = 1'b0;
      r.pl1 = 1'b0;
      r.look_ahead = 1'b0;
      r.long4 = 1'b1;
      r.cur_lim = `CUR_LIM_MAX;
      return r;
   endfunction

   // Next state: register port, command sequencing and feature decode
   always_comb begin
      logic [4:0] xt;
      logic [2:0] xm;
      xt = s_q.sec_cnt[7:3];
      xm = s_q.sec_cnt[2:0];
      s_d = s_q;
      exec_ok = 1'b0;
      s_d.done = 1'b0;
      s_d.rdata = 8'h00;
      // Read data stand one cycle after the strobe
      if (reg_rd_in) begin
         case (reg_addr_in)
            `OFS_ERR_FEAT: s_d.rdata = {5'h00, s_q.err, 2'h0};
            `OFS_SEC_CNT: s_d.rdata = s_q.sec_cnt;
            `OFS_CYL_LO: s_d.rdata = s_q.cyl_lo;
            `OFS_CYL_HI: s_d.rdata = s_q.cyl_hi;
            `OFS_CMD_STAT: s_d.rdata = {s_q.busy, ~s_q.busy, 5'h00, s_q.err};
            `OFS_FEAT_FLAGS: s_d.rdata = {s_q.por_restore, s_q.long4, s_q.look_ahead,
               s_q.pl1, s_q.ext_pwr, s_q.apm_en, s_q.wcache, s_q.eight_bit};
            `OFS_XFER_MODE: s_d.rdata = {s_q.dma_udma, s_q.dma_mode, s_q.iordy_out, s_q.pio};
            `OFS_APM_LEVEL: s_d.rdata = s_q.apm_lvl;
            `OFS_CUR_LIMIT: s_d.rdata = s_q.cur_lim;
            default: s_d.rdata = 8'h00;
         endcase
      end
      case (s_q.state)
         // Task-file writes only land while idle; a busy device ignores them
         set_features_pkg::ST_IDLE: begin
            if (reg_wr_in) begin
               case (reg_addr_in)
                  `OFS_ERR_FEAT: s_d.feat = reg_wdata_in;
                  `OFS_SEC_CNT: s_d.sec_cnt = reg_wdata_in;
                  `OFS_CYL_LO: s_d.cyl_lo = reg_wdata_in;
                  `OFS_CYL_HI: s_d.cyl_hi = reg_wdata_in;
                  `OFS_CMD_STAT: begin
                     if (reg_wdata_in == `OPC_SET_FEATURES) begin
                        s_d.busy = 1'b1;
                        s_d.err = 1'b0;
                        s_d.state = set_features_pkg::ST_EXEC;
                     end
                  end
                  default: s_d.busy = s_q.busy;
               endcase
            end
         end
         // One cycle of decode; a rejected subcommand touches nothing
         set_features_pkg::ST_EXEC: begin
            exec_ok = 1'b1;
            case (s_q.feat)
               `SUB_8BIT_ON: s_d.eight_bit = 1'b1;
               `SUB_8BIT_OFF: s_d.eight_bit = 1'b0;
               `SUB_WCACHE_ON: s_d.wcache = 1'b1;
               `SUB_WCACHE_OFF: s_d.wcache = 1'b0;
               `SUB_XFER_MODE: begin
                  if (xt == `XT_DEFAULT && xm == 3'h0) begin
                     s_d.pio = 3'h0;
                     s_d.iordy_en = 1'b1;
                  end else if (xt == `XT_DEFAULT && xm == `XM_NO_IORDY) begin
                     s_d.pio = 3'h0;
                     s_d.iordy_en = 1'b0;
                  end else if (xt == `XT_PIO_FC && xm <= `MAX_PIO) begin
                     s_d.pio = xm;
                     s_d.iordy_en = 1'b1;
                  end else if (xt == `XT_MDMA && xm <= `MAX_MDMA) begin
                     s_d.dma_udma = 1'b0;
                     s_d.dma_mode = xm;
                  end else if (xt == `XT_UDMA && xm <= `MAX_UDMA) begin
                     s_d.dma_udma = 1'b1;
                     s_d.dma_mode = xm;
                  end else begin
                     exec_ok = 1'b0;
                  end
               end
               `SUB_APM_ON: begin
                  if (s_q.sec_cnt == `APM_RESERVED_LO || s_q.sec_cnt == `APM_RESERVED_HI) begin
                     exec_ok = 1'b0;
                  end else begin
                     // Level is only recorded; no power behaviour follows it
                     s_d.apm_en = 1'b1;
                     s_d.apm_lvl = s_q.sec_cnt;
                  end
               end
               `SUB_APM_OFF: begin
                  if (`APM_OFF_SUPPORTED) begin
                     s_d.apm_en = 1'b0;
                  end else begin
                     exec_ok = 1'b0;
                  end
               end
               `SUB_EXTPWR_ON: s_d.ext_pwr = 1'b1;
               `SUB_EXTPWR_OFF: s_d.ext_pwr = 1'b0;
               `SUB_PL1_ON: s_d.pl1 = 1'b1;
               `SUB_PL1_OFF: s_d.pl1 = 1'b0;
               `SUB_RLA_OFF: s_d.look_ahead = 1'b0;
               `SUB_RLA_ON: s_d.look_ahead = 1'b1;
               `SUB_LONG4: s_d.long4 = 1'b1;
               `SUB_POR_KEEP: s_d.por_restore = 1'b0;
               `SUB_POR_RESTORE: s_d.por_restore = 1'b1;
               `SUB_NOP_A, `SUB_NOP_B, `SUB_NOP_C: exec_ok = 1'b1;
               `SUB_CUR_LIMIT: begin
                  // Out-of-range requests clamp rather than abort
                  if (s_q.sec_cnt < `CUR_LIM_MIN) begin
                     s_d.cur_lim = `CUR_LIM_MIN;
                  end else if (s_q.sec_cnt > `CUR_LIM_MAX) begin
                     s_d.cur_lim = `CUR_LIM_MAX;
                  end else begin
                     s_d.cur_lim = s_q.sec_cnt;
                  end
                  s_d.cyl_lo = `CUR_LIM_MIN;
                  s_d.cyl_hi = `CUR_LIM_MAX;
               end
               default: exec_ok = 1'b0;
            endcase
            // Cache-off must drain before completion is reported
            if (exec_ok && s_q.feat == `SUB_WCACHE_OFF) begin
               s_d.flush_req = 1'b1;
               s_d.state = set_features_pkg::ST_FLUSH;
            end else begin
               s_d.busy = 1'b0;
               s_d.err = ~exec_ok;
               s_d.done = 1'b1;
               s_d.state = set_features_pkg::ST_IDLE;
            end
         end
         // Hold busy until the flush engine reports the cache clean
         set_features_pkg::ST_FLUSH: begin
            if (flush_done_in) begin
               s_d.flush_req = 1'b0;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               s_d.state = set_features_pkg::ST_IDLE;
            end
         end
         default: begin
            s_d.busy = 1'b0;
            s_d.flush_req = 1'b0;
            s_d.state = set_features_pkg::ST_IDLE;
         end
      endcase
      // Soft reset wins over a decode in the same cycle
      if (soft_reset_in && s_q.por_restore) begin
         s_d = with_defaults(s_d);
      end
      s_d.iordy_out = s_d.iordy_en | (s_d.pio >= `PIO_IORDY_MIN);
      s_d.wide_n = s_d.eight_bit;
   end

   // State register; power-on and hardware reset restore every default
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         s_q <= '{state: set_features_pkg::ST_IDLE, por_restore: 1'b1, long4: 1'b1,
            iordy_en: 1'b1, iordy_out: 1'b1, apm_lvl: `APM_RESERVED_HI,
            cur_lim: `CUR_LIM_MAX, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata_out = s_q.rdata;
   assign flush_req_out = s_q.flush_req;
   assign busy_out = s_q.busy;
   assign cmd_done_out = s_q.done;
   assign cmd_abort_out = s_q.err;
   assign wide_transfer_indicator_n_out = s_q.wide_n;
   assign write_cache_en_out = s_q.wcache;
   assign pio_mode_out = s_q.pio;
   assign iordy_en_out = s_q.iordy_out;
   assign dma_is_udma_out = s_q.dma_udma;
   assign dma_mode_out = s_q.dma_mode;
   assign apm_en_out = s_q.apm_en;
   assign apm_level_out = s_q.apm_lvl;
   assign ext_power_en_out = s_q.ext_pwr;
   assign pl1_en_out = s_q.pl1;
   assign look_ahead_en_out = s_q.look_ahead;
   assign long_4byte_out = s_q.long4;
   assign current_limit_out = s_q.cur_lim;
   assign por_restore_out = s_q.por_restore;

   // Checks on the decode and the command sequence
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   property p_abort_keeps;
      (s_q.state == set_features_pkg::ST_EXEC && !exec_ok && !soft_reset_in) |=>
         s_q.err && s_q.done && $stable({s_q.wcache, s_q.pio, s_q.dma_mode, s_q.apm_lvl});
   endproperty
   a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed state");

   property p_eight_bit;
      s_q.eight_bit |-> wide_transfer_indicator_n_out;
   endproperty
   a_eight_bit: assert property (p_eight_bit) else $error("wide indication in 8-bit");

   property p_flush_busy;
      (s_q.state == set_features_pkg::ST_EXEC && s_q.feat == `SUB_WCACHE_OFF) |=>
         flush_req_out && busy_out && !cmd_done_out;
   endproperty
   a_flush_busy: assert property (p_flush_busy) else $error("cache off without flush");

   property p_udma_cancels;
      (s_q.state == set_features_pkg::ST_EXEC && s_q.feat == `SUB_XFER_MODE &&
         s_q.sec_cnt[7:3] == `XT_UDMA && s_q.sec_cnt[2:0] <= `MAX_UDMA && !soft_reset_in)
         |=> dma_is_udma_out && dma_mode_out == $past(s_q.sec_cnt[2:0]);
   endproperty
   a_udma_cancels: assert property (p_udma_cancels) else $error("udma not selected");

   property p_iordy_high_pio;
      (pio_mode_out >= `PIO_IORDY_MIN) |-> iordy_en_out;
   endproperty
   a_iordy_high_pio: assert property (p_iordy_high_pio) else $error("iordy off at pio3+");

   property p_cur_clamp;
      (s_q.state == set_features_pkg::ST_EXEC && s_q.feat == `SUB_CUR_LIMIT &&
         s_q.sec_cnt > `CUR_LIM_MAX && !soft_reset_in) |=> current_limit_out == `CUR_LIM_MAX;
   endproperty
   a_cur_clamp: assert property (p_cur_clamp) else $error("limit not clamped");

   property p_cur_range;
      (s_q.state == set_features_pkg::ST_EXEC && s_q.feat == `SUB_CUR_LIMIT) |=>
         s_q.cyl_lo == `CUR_LIM_MIN && s_q.cyl_hi == `CUR_LIM_MAX && !cmd_abort_out;
   endproperty
   a_cur_range: assert property (p_cur_range) else $error("range not reported");

   property p_busy_start;
      (reg_wr_in && reg_addr_in == `OFS_CMD_STAT && reg_wdata_in == `OPC_SET_FEATURES &&
         !busy_out) |=> busy_out ##1 (busy_out == flush_req_out);
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy sequence wrong");

   property p_apm_reserved;
      (s_q.state == set_features_pkg::ST_EXEC && s_q.feat == `SUB_APM_ON &&
         s_q.sec_cnt == `APM_RESERVED_HI) |=> cmd_abort_out && cmd_done_out;
   endproperty
   a_apm_reserved: assert property (p_apm_reserved) else $error("reserved apm taken");

   property p_nop;
      (s_q.state == set_features_pkg::ST_EXEC && s_q.feat == `SUB_NOP_C && !soft_reset_in)
         |=> !cmd_abort_out && $stable({s_q.wcache, s_q.pio, s_q.cur_lim, s_q.apm_en});
   endproperty
   a_nop: assert property (p_nop) else $error("nop changed state");

   property p_mdma_cancels;
      (s_q.state == set_features_pkg::ST_EXEC && s_q.feat == `SUB_XFER_MODE &&
         s_q.sec_cnt[7:3] == `XT_MDMA && s_q.sec_cnt[2:0] <= `MAX_MDMA && !soft_reset_in)
         |=> !dma_is_udma_out && dma_mode_out == $past(s_q.sec_cnt[2:0]);
   endproperty
   a_mdma_cancels: assert property (p_mdma_cancels) else $error("mdma not selected");

   property p_soft_defaults;
      (soft_reset_in && por_restore_out) |=> !write_cache_en_out && pio_mode_out == 3'h0 &&
         apm_level_out == `APM_RESERVED_HI && current_limit_out == `CUR_LIM_MAX;
   endproperty
   a_soft_defaults: assert property (p_soft_defaults) else $error("soft defaults lost");

   property p_soft_ignored;
      (soft_reset_in && !por_restore_out && s_q.state == set_features_pkg::ST_IDLE) |=>
         $stable({write_cache_en_out, pio_mode_out, apm_level_out, current_limit_out});
   endproperty
   a_soft_ignored: assert property (p_soft_ignored) else $error("soft reset acted");

endmodule // set_features_command_handler
`default_nettype wire

// ===== src/set_features_consts.svh
// Offsets, opcodes, subcommands, capabilities and defaults of the set-features handler
`ifndef SET_FEATURES_CONSTS_SVH
`define SET_FEATURES_CONSTS_SVH
// Task-file and feature-state register offsets
`define OFS_ERR_FEAT 4'h1
`define OFS_SEC_CNT 4'h2
`define OFS_CYL_LO 4'h4
`define OFS_CYL_HI 4'h5
`define OFS_CMD_STAT 4'h7
`define OFS_FEAT_FLAGS 4'h8
`define OFS_XFER_MODE 4'h9
`define OFS_APM_LEVEL 4'hA
`define OFS_CUR_LIMIT 4'hB
// Command opcode and subcommands
`define OPC_SET_FEATURES 8'hEF
`define SUB_8BIT_ON 8'h01
`define SUB_8BIT_OFF 8'h81
`define SUB_WCACHE_ON 8'h02
`define SUB_WCACHE_OFF 8'h82
`define SUB_XFER_MODE 8'h03
`define SUB_APM_ON 8'h05
`define SUB_APM_OFF 8'h85
`define SUB_EXTPWR_ON 8'h09
`define SUB_EXTPWR_OFF 8'h89
`define SUB_PL1_ON 8'h0A
`define SUB_PL1_OFF 8'h8A
`define SUB_RLA_OFF 8'h55
`define SUB_RLA_ON 8'hAA
`define SUB_POR_KEEP 8'h66
`define SUB_POR_RESTORE 8'hCC
`define SUB_NOP_A 8'h69
`define SUB_NOP_B 8'h96
`define SUB_NOP_C 8'h97
`define SUB_CUR_LIMIT 8'h9A
`define SUB_LONG4 8'hBB
// Transfer type and mode field codes
`define XT_DEFAULT 5'h00
`define XT_PIO_FC 5'h01
`define XT_MDMA 5'h04
`define XT_UDMA 5'h08
`define XM_NO_IORDY 3'h1
// Capabilities (plain defaults)
`define MAX_PIO 3'h4
`define MAX_MDMA 3'h2
`define MAX_UDMA 3'h6
`define APM_OFF_SUPPORTED 1'b1
`define CUR_LIM_MIN 8'h01
`define CUR_LIM_MAX 8'h7D
`define APM_RESERVED_LO 8'h00
`define APM_RESERVED_HI 8'hFF
`define PIO_IORDY_MIN 3'h3
`endif

// ===== src/set_features_pkg.sv
// Types of the set-features handler
package set_features_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_FLUSH = 3'b100
   } state_type;
   typedef struct packed {
      state_type state;
      logic busy;
      logic err;
      logic done;
      logic flush_req;
      logic [7:0] rdata;
      logic [7:0] feat;
      logic [7:0] sec_cnt;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic eight_bit;
      logic wide_n;
      logic wcache;
      logic [2:0] pio;
      logic iordy_en;
      logic iordy_out;
      logic dma_udma;
      logic [2:0] dma_mode;
      logic apm_en;
      logic [7:0] apm_lvl;
      logic ext_pwr;
      logic pl1;
      logic look_ahead;
      logic long4;
      logic [7:0] cur_lim;
      logic por_restore;
   } ctl_type;
endpackage

// ===== verification/flush_responder.sv
// Behavioural model of the store that answers write-cache flush requests
`timescale 1ns/1ps
`default_nettype none
module flush_responder (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // Flush handshake
   input wire logic flush_req_in,
   input wire logic [7:0] delay_in,
   output logic flush_done_out
);
   logic [7:0] wait_q = 8'h00;
   logic fire_q = 1'b0;
   assign flush_done_out = fire_q;
   // Count the programmed latency, then pulse once; a slow store just counts longer
   always @(posedge ref_clk_in) begin
      if (srst_in || !flush_req_in || fire_q) begin
         wait_q <= 8'h00;
         fire_q <= 1'b0;
      end else if (wait_q == delay_in) begin
         fire_q <= 1'b1;
      end else begin
         wait_q <= wait_q + 8'h01;
      end
   end
endmodule // flush_responder
`default_nettype wire

// ===== verification/set_features_command_handler_bench.sv
// Self-checking bench of the set-features command handler
`include "set_features_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module set_features_command_handler_bench;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic soft_rst = 1'b0;
   logic [7:0] flush_delay = 8'h02;
   logic flush_done, flush_req, busy, done, wide_n, iordy, rd_q;
   logic abort, wcache_en, is_udma, apm_on, ext_on, pl1_on, la_on, long4_on, por_on;
   logic [2:0] pio, dma_mode;
   logic [7:0] apm_lvl, cur_lim;
   logic [7:0] rdata, v, e;
   logic [7:0] exp_q[$];
   int n_fail = 0;
   int comparisons = 0;

   set_features_command_handler u_dut (
      .ref_clk_in(ref_clk), .srst_in(srst), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .soft_reset_in(soft_rst),
      .flush_done_in(flush_done), .flush_req_out(flush_req), .busy_out(busy),
      .cmd_done_out(done), .cmd_abort_out(abort), .wide_transfer_indicator_n_out(wide_n),
      .write_cache_en_out(wcache_en), .pio_mode_out(pio), .iordy_en_out(iordy),
      .dma_is_udma_out(is_udma), .dma_mode_out(dma_mode), .apm_en_out(apm_on),
      .apm_level_out(apm_lvl), .ext_power_en_out(ext_on), .pl1_en_out(pl1_on),
      .look_ahead_en_out(la_on), .long_4byte_out(long4_on), .current_limit_out(cur_lim),
      .por_restore_out(por_on));

   flush_responder u_store (.ref_clk_in(ref_clk), .srst_in(srst), .flush_req_in(flush_req),
      .delay_in(flush_delay), .flush_done_out(flush_done));

   // 200 MHz clock
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [7:0] ex, input logic [7:0] got);
      comparisons++;
      if (got !== ex) begin
         n_fail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, ex, got);
      end
   endtask

   // Read data stands only in the cycle after the strobe, so compare there
   always @(posedge ref_clk) begin
      rd_q <= rd;
      if (rd_q === 1'b1) chk(exp_q.pop_front(), rdata);
   end

   // One bus cycle; every signal changes once, right after an edge
   task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [7:0] ex);
      exp_q.push_back(ex);
      bus(1'b0, 1'b1, a, 8'h00);
   endtask

   task automatic start(input logic [7:0] f, input logic [7:0] c);
      bus(1'b1, 1'b0, `OFS_ERR_FEAT, f);
      bus(1'b1, 1'b0, `OFS_SEC_CNT, c);
      bus(1'b1, 1'b0, `OFS_CMD_STAT, `OPC_SET_FEATURES);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      chk(8'h01, {7'h00, busy});
   endtask

   // Bounded wait for the completion pulse
   task automatic wait_done();
      int i;
      for (i = 0; i < 400; i++) begin
         @(posedge ref_clk);
         if (done === 1'b1) break;
      end
      if (i == 400) begin
         n_fail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, 1'b1, done);
      end
   endtask

   // Feature pins must agree with the register view of the same state
   task automatic chk_pins(input logic [3:0] a, input logic [7:0] ex);
      logic [7:0] p;
      case (a)
         `OFS_FEAT_FLAGS: p = {por_on, long4_on, la_on, pl1_on, ext_on, apm_on, wcache_en, wide_n};
         `OFS_XFER_MODE: p = {is_udma, dma_mode, iordy, pio};
         `OFS_APM_LEVEL: p = apm_lvl;
         `OFS_CUR_LIMIT: p = cur_lim;
         default: p = {5'h00, abort, 2'h0};
      endcase
      chk(ex, p);
   endtask

   // Command, then status (abort bit) and one register readback
   task automatic step(input logic [7:0] f, c, input logic [3:0] a, input logic [7:0] ex,
                       input logic ab);
      start(f, c);
      wait_done();
      rd_reg(`OFS_CMD_STAT, {7'b0100000, ab});
      rd_reg(a, ex);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      chk({7'h00, ab}, {7'h00, abort});
      chk_pins(a, ex);
   endtask

   task automatic pulse_soft();
      soft_rst <= 1'b1;
      @(posedge ref_clk);
      soft_rst <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic test_done();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Whole run needs a few hundred cycles; cut a hang well beyond that
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("watchdog expired");
      test_done();
   end

   initial begin
      v = 8'($urandom(52));
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      rd_reg(`OFS_FEAT_FLAGS, 8'hC0);
      rd_reg(`OFS_XFER_MODE, 8'h08);
      rd_reg(`OFS_APM_LEVEL, 8'hFF);
      rd_reg(`OFS_CUR_LIMIT, 8'h7D);
      rd_reg(`OFS_CMD_STAT, 8'h40);
      bus(1'b1, 1'b0, `OFS_CMD_STAT, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      chk(8'h00, {7'h00, busy});
      $display("test reset done");
      step(`SUB_8BIT_ON, 8'h00, `OFS_FEAT_FLAGS, 8'hC1, 1'b0);
      chk(8'h01, {7'h00, wide_n});
      step(`SUB_8BIT_OFF, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      chk(8'h00, {7'h00, wide_n});
      step(`SUB_EXTPWR_ON, 8'h00, `OFS_FEAT_FLAGS, 8'hC8, 1'b0);
      step(`SUB_EXTPWR_OFF, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      step(`SUB_PL1_ON, 8'h00, `OFS_FEAT_FLAGS, 8'hD0, 1'b0);
      step(`SUB_PL1_OFF, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      step(`SUB_RLA_ON, 8'h00, `OFS_FEAT_FLAGS, 8'hE0, 1'b0);
      step(`SUB_RLA_OFF, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      step(`SUB_POR_KEEP, 8'h00, `OFS_FEAT_FLAGS, 8'h40, 1'b0);
      step(`SUB_POR_RESTORE, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      step(`SUB_NOP_A, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      step(`SUB_NOP_B, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      step(`SUB_NOP_C, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      step(`SUB_LONG4, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      step(8'h77, 8'h00, `OFS_ERR_FEAT, 8'h04, 1'b1);
      $display("test flags done");
      step(`SUB_WCACHE_ON, 8'h00, `OFS_FEAT_FLAGS, 8'hC2, 1'b0);
      flush_delay <= 8'd30;
      start(`SUB_WCACHE_OFF, 8'h00);
      repeat (5) @(posedge ref_clk);
      chk(8'h01, {7'h00, flush_req});
      rd_reg(`OFS_CMD_STAT, 8'h80);
      bus(1'b1, 1'b0, `OFS_SEC_CNT, 8'h5A);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      wait_done();
      rd_reg(`OFS_SEC_CNT, 8'h00);
      rd_reg(`OFS_FEAT_FLAGS, 8'hC0);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      $display("test flush done");
      step(`SUB_XFER_MODE, 8'h0A, `OFS_XFER_MODE, 8'h0A, 1'b0);
      step(`SUB_XFER_MODE, 8'h01, `OFS_XFER_MODE, 8'h00, 1'b0);
      chk(8'h00, {7'h00, iordy});
      step(`SUB_XFER_MODE, 8'h0B, `OFS_XFER_MODE, 8'h0B, 1'b0);
      chk(8'h01, {7'h00, iordy});
      step(`SUB_XFER_MODE, 8'h0C, `OFS_XFER_MODE, 8'h0C, 1'b0);
      step(`SUB_XFER_MODE, 8'h0D, `OFS_XFER_MODE, 8'h0C, 1'b1);
      step(`SUB_XFER_MODE, 8'h46, `OFS_XFER_MODE, 8'hEC, 1'b0);
      step(`SUB_XFER_MODE, 8'h22, `OFS_XFER_MODE, 8'h2C, 1'b0);
      step(`SUB_XFER_MODE, 8'h47, `OFS_XFER_MODE, 8'h2C, 1'b1);
      step(`SUB_XFER_MODE, 8'h23, `OFS_XFER_MODE, 8'h2C, 1'b1);
      step(`SUB_XFER_MODE, 8'h10, `OFS_XFER_MODE, 8'h2C, 1'b1);
      step(`SUB_XFER_MODE, 8'h80, `OFS_XFER_MODE, 8'h2C, 1'b1);
      step(`SUB_XFER_MODE, 8'h41, `OFS_XFER_MODE, 8'h9C, 1'b0);
      step(`SUB_XFER_MODE, 8'h00, `OFS_XFER_MODE, 8'h98, 1'b0);
      $display("test modes done");
      step(`SUB_APM_ON, 8'h80, `OFS_APM_LEVEL, 8'h80, 1'b0);
      rd_reg(`OFS_FEAT_FLAGS, 8'hC4);
      step(`SUB_APM_ON, 8'h00, `OFS_APM_LEVEL, 8'h80, 1'b1);
      step(`SUB_APM_ON, 8'hFF, `OFS_APM_LEVEL, 8'h80, 1'b1);
      step(`SUB_APM_ON, 8'h01, `OFS_APM_LEVEL, 8'h01, 1'b0);
      step(`SUB_APM_ON, 8'hFE, `OFS_APM_LEVEL, 8'hFE, 1'b0);
      step(`SUB_APM_OFF, 8'h00, `OFS_FEAT_FLAGS, 8'hC0, 1'b0);
      $display("test power management done");
      step(`SUB_CUR_LIMIT, 8'h06, `OFS_CUR_LIMIT, 8'h06, 1'b0);
      rd_reg(`OFS_CYL_LO, `CUR_LIM_MIN);
      rd_reg(`OFS_CYL_HI, `CUR_LIM_MAX);
      step(`SUB_CUR_LIMIT, 8'hFF, `OFS_CUR_LIMIT, 8'h7D, 1'b0);
      step(`SUB_CUR_LIMIT, 8'h00, `OFS_CUR_LIMIT, 8'h01, 1'b0);
      // Random limits over 0 to 255 check the upper clamp and the pass-through band; only 0 takes the lower clamp
      repeat (6) begin
         v = 8'($urandom_range(255, 0));
         e = (v < 8'h01) ? 8'h01 : ((v > 8'h7D) ? 8'h7D : v);
         step(`SUB_CUR_LIMIT, v, `OFS_CUR_LIMIT, e, 1'b0);
      end
      $display("test current limit done");
      step(`SUB_WCACHE_ON, 8'h00, `OFS_FEAT_FLAGS, 8'hC2, 1'b0);
      pulse_soft();
      rd_reg(`OFS_FEAT_FLAGS, 8'hC0);
      rd_reg(`OFS_XFER_MODE, 8'h08);
      rd_reg(`OFS_APM_LEVEL, 8'hFF);
      rd_reg(`OFS_CUR_LIMIT, 8'h7D);
      step(`SUB_POR_KEEP, 8'h00, `OFS_FEAT_FLAGS, 8'h40, 1'b0);
      step(`SUB_WCACHE_ON, 8'h00, `OFS_FEAT_FLAGS, 8'h42, 1'b0);
      pulse_soft();
      rd_reg(`OFS_FEAT_FLAGS, 8'h42);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      @(posedge ref_clk);
      $display("test soft reset done");
      test_done();
   end
endmodule // set_features_command_handler_bench
`default_nettype wire
